/* File: logic/psgt_top.sv */
// Function
// - Full rate: ratio 1/1, 1/2, 1/4 by band.
// - Half rate: 1/2 low bands, 1/4 top band.
// - Aux output: divided clock, marker, burst, off.
// - Marker position in 8-bit steps, bounded.
// - Short patterns stretched to multiple >= 512.
// - Mixed marker placed by block and row.
// - Burst delay and width in 8-bit steps.
// - Repeat period is INT(length/128) times 128, the frame when mixed.
// - Timing width bounded by lcm minus 128.
// - Mixed timing width bounded by frame minus 128.
// - Timing delay shares width range and steps.
`timescale 1ns/10ps
`default_nettype none
module psgt_top (
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // APB slave.
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Timing outputs.
    output logic      [1:0]  o_clk_ratio,
    output logic             o_aux,
    output logic             o_gate
);
    import psgt_pkg::*;

    // Adjusted-length calculator states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CALC = 2'b10
    } psgt_st_t;

    // Lowest set bit among bits 0 to 6, else 7.
    function automatic logic [2:0] tz7(input logic [31:0] v);
        logic [2:0] n;
        n = 3'h7;
        for (int k = 6; k >= 0; k--) begin
            if (v[k]) begin
                n = 3'(k);
            end
        end
        return n;
    endfunction : tz7

    // Subtract one 128-bit block, saturate at zero, and cap.
    function automatic logic [BW-1:0] sub_cap(input logic [BW-1:0] v, input logic [BW-1:0] cap);
        logic [BW-1:0] d;
        d = (v > BLK_BITS) ? v - BLK_BITS : '0;
        return (d > cap) ? cap : d;
    endfunction : sub_cap

    // Limit a setting to its largest legal value.
    function automatic logic [BW-1:0] lim(input logic [BW-1:0] v, input logic [BW-1:0] mx);
        return (v > mx) ? mx : v;
    endfunction : lim

    // Limit a one-based index to 1 .. count.
    function automatic logic [8:0] pick(input logic [8:0] v, input logic [8:0] cnt);
        return (v == 9'h000) ? 9'h001 : ((v > cnt) ? cnt : v);
    endfunction : pick

    logic [31:0]   cfg [NRW];     // Software settings.
    logic          plen_wr;       // Pattern length was written.
    logic [31:0]   stat;          // Status word.
    psgt_st_t      st_reg;        // Calculator state.
    psgt_st_t      st_next;
    logic [31:0]   alen_reg;      // Adjusted pattern length.
    logic [31:0]   alen_next;

    // Fields of the control, length and geometry words.
    logic [31:0]   ctrl;
    logic          half;          // Half-rate clock output selected.
    logic [1:0]    band;          // Operating bit-rate band.
    logic [1:0]    aux_src;       // Auxiliary output source.
    logic          gate_en;       // Gating output switched on.
    logic          burst_md;      // Burst sequencing instead of repeat.
    logic          mixed;         // Mixed block pattern.
    logic [31:0]   plen;          // Pattern length in bits.
    logic [31:0]   bcyc;          // Burst cycle in bits.
    logic [31:0]   rowl;          // Mixed row length in bits.
    logic [8:0]    n_rows;        // Mixed rows per block.
    logic [8:0]    n_blks;        // Mixed blocks.

    assign ctrl     = cfg[OFF_CTRL[5:2]];
    assign half     = ctrl[CTRL_HALF];
    assign band     = ctrl[CTRL_BAND +: 2];
    assign aux_src  = ctrl[CTRL_AUX +: 2];
    assign gate_en  = ctrl[CTRL_GATE];
    assign burst_md = ctrl[CTRL_BURST];
    assign mixed    = ctrl[CTRL_MIXED];
    assign plen     = cfg[OFF_PLEN[5:2]];
    assign bcyc     = cfg[OFF_BCYC[5:2]];
    assign rowl     = cfg[OFF_ROWL[5:2]];
    assign n_rows   = {4'h0, cfg[OFF_GEOM[5:2]][SEL_ROW +: 5]};
    assign n_blks   = cfg[OFF_GEOM[5:2]][SEL_BLK +: 9];
    assign stat     = {29'h0000_0000, (st_reg == ST_CALC), o_clk_ratio};

    // Register slave.
    psgt_apb u_apb (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_psel    (i_psel),
        .i_penable (i_penable),
        .i_pwrite  (i_pwrite),
        .i_paddr   (i_paddr),
        .i_pwdata  (i_pwdata),
        .o_prdata  (o_prdata),
        .o_pready  (o_pready),
        .o_pslverr (o_pslverr),
        .o_cfg     (cfg),
        .o_plen_wr (plen_wr),
        .i_stat    (stat),
        .i_alen    (alen_reg)
    );

    // Stretch a short pattern by adding its length until 512 bits are reached.
    always_comb begin
        st_next   = st_reg;
        alen_next = alen_reg;
        case (st_reg)
            ST_IDLE: begin
                if (plen_wr) begin
                    st_next   = ST_CALC;
                    alen_next = (plen == 32'h0000_0000) ? ADJ_MIN : plen;
                end
            end
            ST_CALC: begin
                if (plen_wr) begin
                    alen_next = (plen == 32'h0000_0000) ? ADJ_MIN : plen;
                end else if (alen_reg < ADJ_MIN) begin
                    alen_next = alen_reg + plen;
                end else begin
                    st_next = ST_IDLE;
                end
            end
            default: begin
                st_next = ST_CALC;
            end
        endcase
    end

    // Calculator state; reset starts a calculation from the reset length.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg   <= ST_CALC;
            alen_reg <= RST_PLEN;
        end else begin
            st_reg   <= st_next;
            alen_reg <= alen_next;
        end
    end

    // Derived lengths and bounds, all in bits until shifted to steps.
    logic [BW-1:0] lcm_bits;      // Least common multiple of adjusted length and 128.
    logic [BW-1:0] mix_bits;      // Mixed frame length.
    logic [BW-1:0] tmax_bits;     // Largest timing width or delay.
    logic [BW-1:0] tmax;          // Same, in steps.
    logic [BW-1:0] bmax;          // Largest burst delay or width, in steps.
    logic [BW-1:0] pmax;          // Largest marker index.
    logic [BW-1:0] twid;
    logic [BW-1:0] tdly;
    logic [BW-1:0] bwid;
    logic [BW-1:0] bdly;
    logic [BW-1:0] mpos;
    logic [BW-1:0] rep_per;       // Repeat period in steps.
    logic [BW-1:0] rep_last;
    logic [BW-1:0] mk_last;
    logic [BW-1:0] bc_last;
    logic [BW-1:0] rs_last;
    logic [8:0]    mrow;
    logic [8:0]    mblk;

    assign lcm_bits  = {16'h0000, alen_reg} << (3'h7 - tz7(alen_reg));
    assign mix_bits  = BW'(rowl) * BW'(n_rows) * BW'(n_blks);
    assign tmax_bits = mixed ? sub_cap(mix_bits, MIX_CAP) : sub_cap(lcm_bits, TW_CAP);
    assign tmax      = tmax_bits >> STEP_SH;
    assign bmax      = sub_cap(BW'(bcyc), {BW{1'b1}}) >> STEP_SH;
    assign pmax      = (lcm_bits - MARK_END - 1'b1) >> STEP_SH;
    assign twid      = lim(BW'(cfg[OFF_TWID[5:2]]), tmax);
    assign tdly      = lim(BW'(cfg[OFF_TDLY[5:2]]), tmax);
    assign bwid      = lim(BW'(cfg[OFF_BWID[5:2]]), bmax);
    assign bdly      = lim(BW'(cfg[OFF_BDLY[5:2]]), bmax);
    assign mpos      = lim(BW'(cfg[OFF_MPOS[5:2]]), pmax);
    assign rep_per   = mixed ? (mix_bits >> STEP_SH) : ((BW'(plen) >> BLK_SH) << (BLK_SH - STEP_SH));
    assign rep_last  = (rep_per == '0) ? '0 : rep_per - 1'b1;
    assign mk_last   = (lcm_bits >> STEP_SH) - 1'b1;
    assign bc_last   = ((BW'(bcyc) >> STEP_SH) == '0) ? '0 : (BW'(bcyc) >> STEP_SH) - 1'b1;
    assign rs_last   = ((BW'(rowl) >> STEP_SH) == '0) ? '0 : (BW'(rowl) >> STEP_SH) - 1'b1;
    assign mrow      = pick({4'h0, cfg[OFF_MSEL[5:2]][SEL_ROW +: 5]}, n_rows);
    assign mblk      = pick(cfg[OFF_MSEL[5:2]][SEL_BLK +: 9], n_blks);

    // Step counters for repeat period, marker frame, burst cycle and mixed rows.
    logic [BW-1:0] rep_reg;
    logic [BW-1:0] mk_reg;
    logic [BW-1:0] bc_reg;
    logic [BW-1:0] rs_reg;
    logic [8:0]    ri_reg;        // Row index within the block, from zero.
    logic [8:0]    bi_reg;        // Block index, from zero.
    logic          row_end;
    logic          blk_end;

    assign row_end = (rs_reg >= rs_last);
    assign blk_end = (ri_reg + 1'b1 >= n_rows);

    // Each counter wraps at its last step; a shortened period wraps at once.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rep_reg <= '0;
            mk_reg  <= '0;
            bc_reg  <= '0;
        end else begin
            rep_reg <= (rep_reg >= rep_last) ? '0 : rep_reg + 1'b1;
            mk_reg  <= (mk_reg >= mk_last) ? '0 : mk_reg + 1'b1;
            bc_reg  <= (bc_reg >= bc_last) ? '0 : bc_reg + 1'b1;
        end
    end

    // Row and block walk of a mixed pattern.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rs_reg <= '0;
            ri_reg <= 9'h000;
            bi_reg <= 9'h000;
        end else begin
            rs_reg <= row_end ? '0 : rs_reg + 1'b1;
            ri_reg <= !row_end ? ri_reg : (blk_end ? 9'h000 : ri_reg + 1'b1);
            bi_reg <= !(row_end && blk_end) ? bi_reg :
                      ((bi_reg + 1'b1 >= n_blks) ? 9'h000 : bi_reg + 1'b1);
        end
    end

    // Marker, windows and output selections.
    logic          mk_hit;
    logic          rep_win;
    logic          b_win;
    logic          div_clk;
    logic [9:0]    div_n;
    logic [1:0]    ratio_next;
    logic          aux_next;
    logic          gate_next;

    assign mk_hit     = mixed ? ((rs_reg == '0) && (ri_reg == mrow - 1'b1) && (bi_reg == mblk - 1'b1))
                              : (mk_reg == mpos);
    assign rep_win    = (rep_reg >= tdly) && (rep_reg < tdly + twid);
    assign b_win      = (bc_reg >= bdly) && (bc_reg < bdly + bwid);
    assign div_n      = (cfg[OFF_DIVN[5:2]] > 32'(DIV_MAX)) ? DIV_MAX : cfg[OFF_DIVN[5:2]][9:0];
    assign ratio_next = half ? ((band >= BAND_TOP) ? RATIO_4 : RATIO_2) :
                        (band == BAND_LOW) ? RATIO_1 : (band == BAND_MID) ? RATIO_2 : RATIO_4;
    assign aux_next   = (aux_src == AUX_DIV) ? div_clk :
                        (aux_src == AUX_MARK) ? mk_hit :
                        (aux_src == AUX_BURST) ? b_win : 1'b0;
    assign gate_next  = gate_en && (burst_md ? b_win : rep_win);

    // Divided clock for the auxiliary output.
    psgt_div #(
        .NW (10)
    ) u_div (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_en  (aux_src == AUX_DIV),
        .i_n   (div_n),
        .o_clk (div_clk)
    );

    // Output flops.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_clk_ratio <= RATIO_1;
            o_aux       <= 1'b0;
            o_gate      <= 1'b0;
        end else begin
            o_clk_ratio <= ratio_next;
            o_aux       <= aux_next;
            o_gate      <= gate_next;
        end
    end

    // Checks on the design's own behaviour.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_burst_open;
        gate_en && burst_md && b_win;
    endsequence

    chk_ratio_full: assert property (!half && band == BAND_MID |=> o_clk_ratio == RATIO_2)
        else $error("Full-rate ratio wrong.");
    chk_ratio_half: assert property (half && band == BAND_LOW |=> o_clk_ratio == RATIO_2)
        else $error("Half-rate ratio wrong.");
    chk_aux_off: assert property (aux_src == AUX_OFF |=> !o_aux)
        else $error("Aux output active while off.");
    chk_marker_pulse: assert property (aux_src == AUX_MARK && mk_hit |=> o_aux)
        else $error("Marker pulse missing.");
    chk_adj_len: assert property (st_reg == ST_IDLE |-> alen_reg >= ADJ_MIN)
        else $error("Adjusted length below 512.");
    chk_mixed_mark: assert property (mixed && mk_hit |-> rs_reg == '0 && ri_reg < n_rows)
        else $error("Mixed marker off a row start.");
    chk_burst_gate: assert property (s_burst_open |=> o_gate)
        else $error("Burst window not on gate.");
    chk_rep_wrap: assert property (rep_reg == rep_last && $stable(rep_last) |=> rep_reg == '0)
        else $error("Repeat period wrong.");
    chk_width_cap: assert property (!mixed |-> twid <= (TW_CAP >> STEP_SH) && tmax <= (lcm_bits >> STEP_SH))
        else $error("Timing width out of range.");
    chk_mix_cap: assert property (mixed |-> tmax_bits <= MIX_CAP)
        else $error("Mixed width out of range.");
    chk_delay_cap: assert property (tdly <= tmax)
        else $error("Timing delay out of range.");
    chk_gate_off: assert property (!gate_en |=> !o_gate)
        else $error("Gate driven while switched off.");
endmodule : psgt_top
`default_nettype wire

/* File: logic/psgt_pkg.sv */
`default_nettype none
package psgt_pkg;
    // Register byte offsets, one 32-bit word each.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DIVN = 8'h04;
    localparam logic [7:0] OFF_PLEN = 8'h08;
    localparam logic [7:0] OFF_MPOS = 8'h0C;
    localparam logic [7:0] OFF_MSEL = 8'h10;
    localparam logic [7:0] OFF_BCYC = 8'h14;
    localparam logic [7:0] OFF_BDLY = 8'h18;
    localparam logic [7:0] OFF_BWID = 8'h1C;
    localparam logic [7:0] OFF_TDLY = 8'h20;
    localparam logic [7:0] OFF_TWID = 8'h24;
    localparam logic [7:0] OFF_ROWL = 8'h28;
    localparam logic [7:0] OFF_GEOM = 8'h2C;
    localparam logic [7:0] OFF_STAT = 8'h30;
    localparam logic [7:0] OFF_ALEN = 8'h34;
    // Number of writable words, which sit at the lowest offsets.
    localparam int NRW = 12;
    // Control word field positions.
    localparam int CTRL_HALF  = 0;
    localparam int CTRL_BAND  = 1;
    localparam int CTRL_AUX   = 3;
    localparam int CTRL_GATE  = 5;
    localparam int CTRL_BURST = 6;
    localparam int CTRL_MIXED = 7;
    // Row and block field positions in the select and geometry words.
    localparam int SEL_ROW = 0;
    localparam int SEL_BLK = 16;
    // Bit-rate bands and input clock ratio codes.
    localparam logic [1:0] BAND_LOW = 2'h0;
    localparam logic [1:0] BAND_MID = 2'h1;
    localparam logic [1:0] BAND_TOP = 2'h2;
    localparam logic [1:0] RATIO_1  = 2'h0;
    localparam logic [1:0] RATIO_2  = 2'h1;
    localparam logic [1:0] RATIO_4  = 2'h2;
    // Auxiliary output sources.
    localparam logic [1:0] AUX_OFF   = 2'h0;
    localparam logic [1:0] AUX_DIV   = 2'h1;
    localparam logic [1:0] AUX_MARK  = 2'h2;
    localparam logic [1:0] AUX_BURST = 2'h3;
    // Values after reset.
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_DIVN = 32'h0000_0004;
    localparam logic [31:0] RST_PLEN = 32'h0000_007F;
    localparam logic [31:0] RST_BCYC = 32'h0000_0600;
    localparam logic [31:0] RST_ROWL = 32'h0000_0600;
    localparam logic [31:0] RST_GEOM = 32'h0001_0001;
    localparam logic [NRW-1:0][31:0] RST_VAL = {RST_GEOM, RST_ROWL, RST_ZERO, RST_ZERO,
        RST_ZERO, RST_ZERO, RST_BCYC, RST_ZERO, RST_ZERO, RST_PLEN, RST_DIVN, RST_ZERO};
    // Bit counts; one clock cycle carries one 8-bit step.
    localparam int BW      = 48;
    localparam int STEP_SH = 3;
    localparam int BLK_SH  = 7;
    localparam logic [BW-1:0] BLK_BITS = 48'h0000_0000_0080;
    localparam logic [BW-1:0] MARK_END = 48'h0000_0000_0087;
    localparam logic [BW-1:0] TW_CAP   = 48'h0007_FFFF_FF80;
    localparam logic [BW-1:0] MIX_CAP  = 48'h0000_8FFF_FF80;
    localparam logic [31:0]   ADJ_MIN  = 32'h0000_0200;
    localparam logic [9:0]    DIV_MAX  = 10'h200;
endpackage : psgt_pkg
`default_nettype wire

/* File: logic/psgt_div.sv */
`timescale 1ns/10ps
`default_nettype none
module psgt_div #(
    parameter int NW = 10
) (
    // Clock and reset.
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    // Divider control and output.
    input  wire logic          i_en,
    input  wire logic [NW-1:0] i_n,
    output logic               o_clk
);
    import psgt_pkg::*;

    logic [NW-2:0] cnt_reg;   // Cycles spent in the current half period.
    logic [NW-2:0] half;      // Half period, never below two cycles.
    logic          wrap;      // Last cycle of a half period.

    assign half = (i_n[NW-1:1] < (NW-1)'(2)) ? (NW-1)'(2) : i_n[NW-1:1];
    assign wrap = (cnt_reg == half - 1'b1);

    // Toggle the output every half period while enabled; park low otherwise.
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_en) begin
            cnt_reg <= '0;
            o_clk   <= 1'b0;
        end else begin
            cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
            o_clk   <= wrap ? !o_clk : o_clk;
        end
    end
endmodule : psgt_div
`default_nettype wire

/* File: logic/psgt_apb.sv */
`timescale 1ns/10ps
`default_nettype none
module psgt_apb (
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // APB slave.
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Register contents and status.
    output logic      [31:0] o_cfg [psgt_pkg::NRW],
    output logic             o_plen_wr,
    input  wire logic [31:0] i_stat,
    input  wire logic [31:0] i_alen
);
    import psgt_pkg::*;

    logic [5:0]  idx;     // Word index of the address.
    logic        rw_hit;  // A writable word is addressed.
    logic        ro_hit;  // A read-only word is addressed.
    logic        setup;   // Setup phase of a transfer.
    logic        wr_go;   // Write takes effect at this edge.
    logic [31:0] rd_mux;  // Read data selected by the address.

    assign idx    = i_paddr[7:2];
    assign rw_hit = (i_paddr[1:0] == 2'h0) && (idx < 6'(NRW));
    assign ro_hit = (i_paddr == OFF_STAT) || (i_paddr == OFF_ALEN);
    assign setup  = i_psel && !i_penable;
    assign wr_go  = i_psel && i_penable && o_pready && i_pwrite && rw_hit;
    assign rd_mux = rw_hit ? o_cfg[idx[3:0]] :
                    (i_paddr == OFF_STAT) ? i_stat :
                    (i_paddr == OFF_ALEN) ? i_alen : 32'h0000_0000;

    // Answer every transfer in its first access cycle; unmapped reads or writes and read-only writes error.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_plen_wr <= 1'b0;
        end else begin
            o_pready  <= setup;
            o_pslverr <= setup && !(rw_hit || (ro_hit && !i_pwrite));
            o_prdata  <= (setup && !i_pwrite) ? rd_mux : 32'h0000_0000;
            o_plen_wr <= wr_go && (i_paddr == OFF_PLEN);
        end
    end

    // One storage word per writable register.
    generate
        for (genvar g = 0; g < NRW; g++) begin : g_word
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    o_cfg[g] <= RST_VAL[g];
                end else if (wr_go && (idx == 6'(g))) begin
                    o_cfg[g] <= i_pwdata;
                end
            end
        end
    endgenerate
endmodule : psgt_apb
`default_nettype wire

/* File: dv/psgt_far.sv */
`timescale 1ns/10ps
`default_nettype none
// Far-side receiver: counts what an instrument on the aux and gate lines sees.
module psgt_far (
    // Clock and count window clear.
    input  wire logic        i_clk,
    input  wire logic        i_clr,
    // Observed lines.
    input  wire logic        i_aux,
    input  wire logic        i_gate,
    // Counts since the last clear.
    output logic      [15:0] o_aux_rise,
    output logic      [15:0] o_aux_high,
    output logic      [15:0] o_gate_high
);
    logic aux_q; // Previous aux level, for edge detection.
    // Counts one sample per cycle, so a window of whole periods gives exact figures.
    always_ff @(posedge i_clk) begin
        aux_q <= i_aux;
        if (i_clr) begin
            o_aux_rise  <= '0;
            o_aux_high  <= '0;
            o_gate_high <= '0;
        end else begin
            o_aux_rise  <= o_aux_rise + 16'(i_aux & ~aux_q);
            o_aux_high  <= o_aux_high + 16'(i_aux);
            o_gate_high <= o_gate_high + 16'(i_gate);
        end
    end
endmodule : psgt_far
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import psgt_pkg::*;
    logic        clk, rst, psel, pen, pwr, clr;     // Bench-driven controls.
    logic [7:0]  addr;                              // Bus address.
    logic [31:0] wdata, prdata, rd;                 // Bus data.
    logic        pready, pslverr, err, aux, gate;   // Design outputs and last error.
    logic [1:0]  ratio;                             // Input clock ratio.
    logic [15:0] a_rise, a_high, g_high;            // Far-side counts.
    int          fails = 0;                         // Mismatch count.
    int          num_checks = 0;                    // Comparison count.
    psgt_top u_dut (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(addr), .i_pwdata(wdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_clk_ratio(ratio), .o_aux(aux), .o_gate(gate));
    psgt_far u_far (.i_clk(clk), .i_clr(clr), .i_aux(aux), .i_gate(gate),
        .o_aux_rise(a_rise), .o_aux_high(a_high), .o_gate_high(g_high));
    // Free-running 40 ns clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t %s: saw %h, expected %h", $time, what, seen, exp);
        end
    endtask : check
    // One APB transfer; holds the request until pready is seen at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; addr <= a; wdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) check(32'h1, 32'h0, "no pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb
    // Counts the far-side lines over a window of n cycles.
    task automatic measure(input int n);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask : measure
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    // Watchdog: the tests take about 3700 cycles.
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out();
    end
    // Main test sequence.
    initial begin
        rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; addr = 8'h00; wdata = 32'h0000_0000; clr = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        // Reset values of every writable word, and the stretched short pattern.
        for (int i = 0; i < NRW; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0000_0000);
            check(rd, RST_VAL[i], "reset value");
        end
        apb(1'b0, OFF_ALEN, 32'h0000_0000);
        check(rd, 32'h0000_027B, "127-bit pattern stretched");
        apb(1'b0, 8'h40, 32'h0000_0000);
        check({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
        apb(1'b1, OFF_STAT, 32'h0000_0003);
        check(32'(err), 32'h1, "status write refused");
        $display("test registers done");
        // Every rate mode and band sets the input clock ratio.
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, OFF_CTRL, 32'(i << 1 >> 1));
            repeat (3) @(posedge clk);
            check(32'(ratio), (i[2:1] >= 2) ? 32'h2 : (i[0] ? 32'h1 : 32'(i[2:1])), "ratio");
        end
        $display("test ratio done");
        // Divided clock of period 8 on the aux line.
        apb(1'b1, OFF_DIVN, 32'h0000_0008);
        apb(1'b1, OFF_CTRL, 32'h0000_0008);
        measure(64);
        check(32'(a_rise), 32'h8, "divided clock edges");
        // Marker every 64 steps with the 512-bit stretched length.
        apb(1'b1, OFF_PLEN, 32'h0000_0100);
        repeat (10) @(posedge clk);
        apb(1'b0, OFF_ALEN, 32'h0000_0000);
        check(rd, 32'h0000_0200, "256-bit pattern stretched");
        apb(1'b1, OFF_MPOS, 32'h0000_0003);
        apb(1'b1, OFF_CTRL, 32'h0000_0010);
        repeat (70) @(posedge clk);
        measure(128);
        check(32'(a_rise), 32'h2, "marker count");
        apb(1'b1, OFF_CTRL, 32'h0000_0000);
        measure(64);
        check(32'(a_high), 32'h0, "aux off");
        $display("test aux done");
        // Repeat timing: 1023 bits gives a 7 x 128 bit period of 112 steps.
        apb(1'b1, OFF_PLEN, 32'h0000_03FF);
        apb(1'b1, OFF_TDLY, 32'h0000_0004);
        apb(1'b1, OFF_TWID, 32'h0000_000A);
        apb(1'b1, OFF_CTRL, 32'h0000_0020);
        repeat (300) @(posedge clk);
        apb(1'b0, OFF_ALEN, 32'h0000_0000);
        check(rd, 32'h0000_03FF, "long pattern kept");
        measure(336);
        check(32'(g_high), 32'd30, "timing width");
        apb(1'b1, OFF_CTRL, 32'h0000_0000);
        measure(336);
        check(32'(g_high), 32'h0, "gate off");
        // Burst window: 1536-bit cycle is 192 steps, on both gate and aux.
        apb(1'b1, OFF_BDLY, 32'h0000_0002);
        apb(1'b1, OFF_BWID, 32'h0000_0005);
        apb(1'b1, OFF_CTRL, 32'h0000_0078);
        repeat (200) @(posedge clk);
        measure(384);
        check(32'(g_high), 32'd10, "burst gate width");
        check(32'(a_high), 32'd10, "burst aux width");
        // Mixed: two blocks of two rows of 1536 bits, a frame of 768 steps.
        apb(1'b1, OFF_GEOM, 32'h0002_0002);
        apb(1'b1, OFF_MSEL, 32'h0002_0002);
        apb(1'b1, OFF_TDLY, 32'h0000_0000);
        apb(1'b1, OFF_TWID, 32'h0000_0014);
        apb(1'b1, OFF_CTRL, 32'h0000_00B0);
        repeat (800) @(posedge clk);
        measure(768);
        check(32'(a_rise), 32'h1, "mixed marker");
        check(32'(g_high), 32'd20, "mixed timing width");
        $display("test gating done");
        close_out();
    end
endmodule : testbench
`default_nettype wire
